// file: shared/audio_port_cfg.svh
`ifndef AUDIO_PORT_CFG_SVH
`define AUDIO_PORT_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_AUDIO_FORMAT 8'h04
`define IDX_COMPANDING   8'h05
`define IDX_CLOCK_GEN    8'h06
`define IDX_SAMPLE_RATE  8'h07
`define IDX_STATUS       8'h10
// Reset values
`define RST_AUDIO_FORMAT 9'h050
`define RST_COMPANDING   9'h000
`define RST_CLOCK_GEN    9'h140
`define RST_SAMPLE_RATE  9'h000
// Field positions of the rate register
`define RATE_MSB 3
`define RATE_LSB 1
// Frame and word sizes in bit clocks
`define FRAME_BITS   7'h40
`define FRAME_BITS_8 7'h08
`define WORD_BITS    5'h10
`define WORD_BITS_8  5'h08
`define RJ_DELAY     6'h10
// Internal clock edges per sample (256 clocks, two edges each)
`define SYS_EDGES_PER_FS 10'h200
// Companding constants
`define MU_CLIP   13'h1FDE
`define MU_BIAS   13'h0021
`define MU_INVERT 8'hFF
`define A_INVERT  8'h55
`endif

// file: shared/audio_port_pkg.sv
package audio_port_pkg;
	typedef enum logic [1:0] {COMP_OFF = 2'b00, COMP_RSVD = 2'b01, COMP_MU = 2'b10, COMP_A = 2'b11} comp_mode_type;
	typedef enum logic [1:0] {
		FORMAT_RIGHT = 2'b00, FORMAT_LEFT = 2'b01, FORMAT_I2S = 2'b10, FORMAT_DSP = 2'b11
	} data_format_type;
	typedef enum logic [1:0] {SP_WAIT = 2'b00, SP_DELAY = 2'b01, SP_SHIFT = 2'b10, SP_DONE = 2'b11} port_state_type;
	typedef struct packed {
		logic       clock_source_select;
		logic [2:0] sysclk_divider;
		logic [2:0] bit_clock_divider;
		logic       spare;
		logic       master_select;
	} clock_gen_type;
	typedef struct packed {
		logic [2:0]    spare;
		logic          eight_bit_word_mode;
		comp_mode_type play_comp;
		comp_mode_type rec_comp;
		logic          loopback;
	} compand_type;
	typedef struct packed {
		logic [1:0]      polarity;
		logic [1:0]      word_length;
		data_format_type data_format_select;
		logic [2:0]      channel;
	} audio_format_type;
endpackage

// file: src/frac_divider.sv
`timescale 1ns/1ps
// Divides a tick stream by half_div/2, so odd half_div gives half-integer ratios
module frac_divider (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// Ticks
	input  wire logic       tick_in,
	input  wire logic [6:0] half_div,
	output logic            tick_out
);
	logic [6:0] acc;
	wire  [6:0] sum  = acc + 7'h02;
	wire        wrap = sum >= half_div;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc      <= 7'h00;
			tick_out <= 1'b0;
		end else begin
			tick_out <= tick_in & wrap;
			if (tick_in) begin
				acc <= wrap ? 7'(sum - half_div) : sum;
			end
		end
	end
endmodule

// file: src/g711_codec.sv
`timescale 1ns/1ps
`include "audio_port_cfg.svh"
// Segmented compressor and expander, purely combinational
module g711_codec (
	// Linear to code
	input  wire logic [15:0] lin_in,
	input  wire logic        a_law_in,
	output logic      [7:0]  code_out,
	// Code to linear
	input  wire logic [7:0]  code_in,
	input  wire logic        a_law_out,
	output logic      [15:0] lin_out
);
	logic        sgn;
	logic [15:0] mag;
	logic [12:0] mu_mag;
	logic [11:0] a_mag;
	logic [2:0]  ex;
	logic [3:0]  mt;
	logic [7:0]  dc;
	logic [15:0] t;
	always_comb begin
		sgn = lin_in[15];
		// A-law folds negatives by one's complement, mu-law by two's
		mag = sgn ? (a_law_in ? ~lin_in : 16'(-lin_in)) : lin_in;
		mu_mag = (mag[15:2] > 14'(`MU_CLIP)) ? `MU_CLIP : mag[14:2];
		mu_mag = mu_mag + `MU_BIAS;
		a_mag = mag[14:3];
		ex = 3'h0;
		if (a_law_in) begin
			for (int i = 1; i < 8; i++) begin
				if (a_mag[i + 4]) ex = 3'(i);
			end
			mt = (ex == 3'h0) ? a_mag[4:1] : 4'(a_mag >> ex);
			code_out = {~sgn, ex, mt} ^ `A_INVERT;
		end else begin
			for (int i = 1; i < 8; i++) begin
				if (mu_mag[i + 5]) ex = 3'(i);
			end
			mt = 4'(mu_mag >> ({1'b0, ex} + 4'h1));
			code_out = ~{sgn, ex, mt};
		end
		dc = a_law_out ? (code_in ^ `A_INVERT) : ~code_in;
		if (a_law_out) begin
			t = {8'h00, dc[3:0], 4'h8};
			if (dc[6:4] != 3'h0) t = 16'((t + 16'h0100) << (dc[6:4] - 3'h1));
			lin_out = dc[7] ? t : 16'(-t);
		end else begin
			t = 16'(({9'h000, dc[3:0], 3'h0} + 16'h0084) << dc[6:4]);
			lin_out = dc[7] ? 16'(16'h0084 - t) : 16'(t - 16'h0084);
		end
	end
endmodule

// file: src/audio_port_top.sv
`timescale 1ns/1ps
`include "audio_port_cfg.svh"
module audio_port_top (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Clock sources
	input  wire logic        master_clock_in,
	input  wire logic        pll_clock_in,
	// Serial port pins
	input  wire logic        bit_clock_in,
	output logic             bit_clock_out,
	output logic             bit_clock_oe_n,
	input  wire logic        frame_sync_in,
	output logic             frame_sync_out,
	output logic             frame_sync_oe_n,
	input  wire logic        playback_data_in,
	output logic             record_data_out,
	// Audio path
	input  wire logic [15:0] rec_sample,
	output logic             rec_taken,
	output logic      [15:0] play_sample,
	output logic             play_valid,
	output logic             sample_tick,
	output logic      [2:0]  filter_rate_code
);
	audio_port_pkg::audio_format_type audio_fmt;
	audio_port_pkg::compand_type      compand;
	audio_port_pkg::clock_gen_type    clk_gen;
	logic [8:0]                       rate_reg;
	audio_port_pkg::port_state_type   state;
	logic [4:0]  pin_meta;
	logic [4:0]  pin_sync;
	logic        src_prev;
	logic        sys_tick;
	logic        bit_tick;
	logic [9:0]  fs_cnt;
	logic        m_bclk;
	logic        m_fs;
	logic [6:0]  m_bit_cnt;
	logic        bclk_d;
	logic        fs_d;
	logic [5:0]  dly;
	logic [4:0]  bit_idx;
	logic [15:0] tx;
	logic [15:0] rx;
	logic [7:0]  rec_code;
	logic [15:0] play_lin;
	logic [7:0]  last_rec_code;
	logic [7:0]  last_play_code;
	logic        dp_write;
	logic [7:0]  dp_index;
	logic [6:0]  sys_half;

	// Bus decode; every access completes at once with OKAY
	wire        bus_take = hsel & htrans[1] & hready;
	wire [7:0]  bus_index = haddr[9:2];
	wire        bus_mapped = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'b00);
	wire [31:0] rd_word =
		!bus_mapped ? 32'h00000000 :
		(bus_index == `IDX_AUDIO_FORMAT) ? {23'h000000, audio_fmt} :
		(bus_index == `IDX_COMPANDING)   ? {23'h000000, compand} :
		(bus_index == `IDX_CLOCK_GEN)    ? {23'h000000, clk_gen} :
		(bus_index == `IDX_SAMPLE_RATE)  ? {23'h000000, rate_reg} :
		(bus_index == `IDX_STATUS)       ? {16'h0000, last_play_code, last_rec_code} : 32'h00000000;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dp_write <= 1'b0;
			dp_index <= 8'h00;
			hrdata   <= 32'h00000000;
		end else begin
			dp_write <= bus_take & hwrite & bus_mapped;
			if (bus_take) begin
				dp_index <= bus_index;
			end
			if (bus_take & !hwrite) begin
				hrdata <= rd_word;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			audio_fmt <= audio_port_pkg::audio_format_type'(`RST_AUDIO_FORMAT);
			compand   <= audio_port_pkg::compand_type'(`RST_COMPANDING);
			clk_gen   <= audio_port_pkg::clock_gen_type'(`RST_CLOCK_GEN);
			rate_reg  <= `RST_SAMPLE_RATE;
		end else if (dp_write) begin
			case (dp_index)
				`IDX_AUDIO_FORMAT: audio_fmt <= audio_port_pkg::audio_format_type'(hwdata[8:0]);
				`IDX_COMPANDING:   compand   <= audio_port_pkg::compand_type'(hwdata[8:0]);
				`IDX_CLOCK_GEN:    clk_gen   <= audio_port_pkg::clock_gen_type'(hwdata[8:0]);
				`IDX_SAMPLE_RATE:  rate_reg  <= hwdata[8:0];
				default: begin
				end
			endcase
		end
	end
	assign filter_rate_code = rate_reg[`RATE_MSB:`RATE_LSB];

	// Pins come from other clocks: two flops before use
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta <= 5'h00;
			pin_sync <= 5'h00;
		end else begin
			pin_meta <= {playback_data_in, frame_sync_in, bit_clock_in, pll_clock_in, master_clock_in};
			pin_sync <= pin_meta;
		end
	end

	// Source edges: both edges count, so dividing by two yields one edge per source cycle
	wire master    = clk_gen.master_select;
	wire src_level = clk_gen.clock_source_select ? pin_sync[1] : pin_sync[0];
	wire src_edge  = src_level ^ src_prev;

	always_comb begin
		case (clk_gen.sysclk_divider)
			3'h0: sys_half = 7'h02;
			3'h1: sys_half = 7'h03;
			3'h2: sys_half = 7'h04;
			3'h3: sys_half = 7'h06;
			3'h4: sys_half = 7'h08;
			3'h5: sys_half = 7'h0C;
			3'h6: sys_half = 7'h10;
			default: sys_half = 7'h18;
		endcase
	end
	// Reserved codes fall back to divide by one
	wire [6:0] bit_half = (clk_gen.bit_clock_divider > 3'h5) ? 7'h02 :
		7'(7'h02 << clk_gen.bit_clock_divider);

	frac_divider u_sys_div (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.tick_in  (src_edge),
		.half_div (sys_half),
		.tick_out (sys_tick)
	);

	frac_divider u_bit_div (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.tick_in  (sys_tick),
		.half_div (bit_half),
		.tick_out (bit_tick)
	);

	// Sample strobe for the filters: 256 internal clocks per sample
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			src_prev    <= 1'b0;
			fs_cnt      <= 10'h000;
			sample_tick <= 1'b0;
		end else begin
			src_prev    <= src_level;
			sample_tick <= sys_tick & (fs_cnt == `SYS_EDGES_PER_FS - 10'h001);
			if (sys_tick) begin
				fs_cnt <= (fs_cnt == `SYS_EDGES_PER_FS - 10'h001) ? 10'h000 : fs_cnt + 10'h001;
			end
		end
	end

	// Master framing
	wire       word8        = compand.eight_bit_word_mode;
	wire       fmt_dsp      = audio_fmt.data_format_select == audio_port_pkg::FORMAT_DSP;
	wire [6:0] frame_len    = word8 ? `FRAME_BITS_8 : `FRAME_BITS;
	wire [6:0] frame_half   = {1'b0, frame_len[6:1]};
	wire       m_fall       = master & bit_tick & m_bclk;
	wire [6:0] next_bit_cnt = (m_bit_cnt >= frame_len - 7'h01) ? 7'h00 : m_bit_cnt + 7'h01;
	wire       next_m_fs    = fmt_dsp ? (next_bit_cnt == 7'h00) : (next_bit_cnt >= frame_half);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			m_bclk    <= 1'b0;
			m_fs      <= 1'b0;
			m_bit_cnt <= 7'h00;
		end else if (!master) begin
			m_bclk    <= 1'b0;
			m_fs      <= 1'b0;
			m_bit_cnt <= 7'h00;
		end else begin
			if (bit_tick) begin
				m_bclk <= ~m_bclk;
			end
			if (m_fall) begin
				m_bit_cnt <= next_bit_cnt;
				m_fs      <= next_m_fs;
			end
		end
	end
	assign bit_clock_out   = m_bclk;
	assign frame_sync_out  = m_fs;
	assign bit_clock_oe_n  = ~master;
	assign frame_sync_oe_n = ~master;

	// Line levels seen by the serial engine, own or received
	wire bclk_lvl    = master ? m_bclk : pin_sync[2];
	wire fs_lvl      = master ? m_fs : pin_sync[3];
	wire bclk_rise   = bclk_lvl & ~bclk_d;
	wire bclk_fall   = ~bclk_lvl & bclk_d;
	// DSP frames open on a rising sync, the others on the left phase (low)
	wire frame_start = fmt_dsp ? (fs_lvl & ~fs_d) : (~fs_lvl & fs_d);

	wire [4:0] word_len = word8 ? `WORD_BITS_8 : `WORD_BITS;
	wire [5:0] start_dly =
		(audio_fmt.data_format_select == audio_port_pkg::FORMAT_I2S) ? 6'h01 :
		(audio_fmt.data_format_select == audio_port_pkg::FORMAT_RIGHT && !word8) ? `RJ_DELAY : 6'h00;
	wire        rec_on    = compand.rec_comp[1];
	wire        play_on   = compand.play_comp[1];
	wire [15:0] rec_word  = rec_on ? {rec_code, 8'h00} : rec_sample;
	wire [7:0]  play_code = word8 ? rx[7:0] : rx[15:8];
	wire [15:0] play_word = play_on ? play_lin : (word8 ? {rx[7:0], 8'h00} : rx);
	wire        ser_in    = compand.loopback ? record_data_out : pin_sync[4];

	g711_codec u_codec (
		.lin_in    (rec_sample),
		.a_law_in  (compand.rec_comp[0]),
		.code_out  (rec_code),
		.code_in   (play_code),
		.a_law_out (compand.play_comp[0]),
		.lin_out   (play_lin)
	);

	// Serial engine: loads on frame start, bits out on falls, in on rises
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bclk_d          <= 1'b0;
			fs_d            <= 1'b0;
			state           <= audio_port_pkg::SP_WAIT;
			dly             <= 6'h00;
			bit_idx         <= 5'h00;
			tx              <= 16'h0000;
			rx              <= 16'h0000;
			record_data_out <= 1'b0;
			rec_taken       <= 1'b0;
			play_valid      <= 1'b0;
			play_sample     <= 16'h0000;
			last_rec_code   <= 8'h00;
			last_play_code  <= 8'h00;
		end else begin
			bclk_d          <= bclk_lvl;
			fs_d            <= fs_lvl;
			rec_taken       <= frame_start;
			play_valid      <= 1'b0;
			record_data_out <= (state == audio_port_pkg::SP_SHIFT) & tx[15];
			if (frame_start) begin
				tx            <= rec_word;
				rx            <= 16'h0000;
				bit_idx       <= 5'h00;
				dly           <= start_dly;
				last_rec_code <= rec_code;
				state         <= (start_dly == 6'h00) ? audio_port_pkg::SP_SHIFT : audio_port_pkg::SP_DELAY;
			end else begin
				case (state)
					audio_port_pkg::SP_WAIT: begin
					end
					audio_port_pkg::SP_DELAY: begin
						if (bclk_rise) begin
							dly   <= dly - 6'h01;
							state <= (dly == 6'h01) ? audio_port_pkg::SP_SHIFT : audio_port_pkg::SP_DELAY;
						end
					end
					audio_port_pkg::SP_SHIFT: begin
						if (bclk_fall && bit_idx != 5'h00) begin
							tx <= {tx[14:0], 1'b0};
						end
						if (bclk_rise) begin
							rx      <= {rx[14:0], ser_in};
							bit_idx <= bit_idx + 5'h01;
							if (bit_idx == word_len - 5'h01) begin
								state <= audio_port_pkg::SP_DONE;
							end
						end
					end
					audio_port_pkg::SP_DONE: begin
						play_sample    <= play_word;
						play_valid     <= 1'b1;
						last_play_code <= play_code;
						state          <= audio_port_pkg::SP_WAIT;
					end
					default: state <= audio_port_pkg::SP_WAIT;
				endcase
			end
		end
	end

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_last_bit;
		(state == audio_port_pkg::SP_SHIFT) && bclk_rise && !frame_start && (bit_idx == word_len - 5'h01);
	endsequence
	sequence s_word_out;
		(state == audio_port_pkg::SP_DONE) ##1 play_valid;
	endsequence

	a_slave_pins:
	assert property (!master && !$past(master) |-> bit_clock_oe_n && frame_sync_oe_n && !bit_clock_out && !frame_sync_out)
		else $error("serial clocks driven in slave mode");
	a_bclk_step:
	assert property (master && $past(master) && $changed(m_bclk) |-> $past(bit_tick))
		else $error("bit clock moved without a divider tick");
	a_sys_tick:
	assert property (sys_tick |-> $past(src_edge))
		else $error("internal clock tick without source edge");
	a_loop_route:
	assert property (compand.loopback && (state == audio_port_pkg::SP_SHIFT) && bclk_rise && !frame_start
		|=> rx[0] == $past(record_data_out))
		else $error("loopback bit not taken from record output");
	a_mu_zero:
	assert property (rec_sample == 16'h0000 && compand.rec_comp == audio_port_pkg::COMP_MU |-> rec_code == `MU_INVERT)
		else $error("mu-law zero not fully inverted");
	a_alaw_zero:
	assert property (rec_sample == 16'h0000 && compand.rec_comp == audio_port_pkg::COMP_A
		|-> rec_code == (8'h80 ^ `A_INVERT))
		else $error("A-law zero not even-bit inverted");
	a_msb_place:
	assert property (frame_start && rec_on |=> tx[7:0] == 8'h00 && tx[15:8] == $past(rec_code))
		else $error("companded code not in top byte");
	a_word_done:
	assert property (s_last_bit |=> s_word_out)
		else $error("word end not followed by playback strobe");
	a_frame_eight:
	assert property (master && word8 && m_fall |=> m_bit_cnt < `FRAME_BITS_8)
		else $error("8-bit frame longer than 8 bit clocks");
	a_fs_rate:
	assert property (sample_tick |-> $past(sys_tick) && $past(fs_cnt) == `SYS_EDGES_PER_FS - 10'h001)
		else $error("sample strobe not every 256 internal clocks");
endmodule

// file: verif/host_port_model.sv
`timescale 1ns/1ps
// Host audio port acting as clock master while the block is a slave
module host_port_model (
	// Core clock for pacing
	input  wire logic core_clk,
	// Serial pins
	output logic      bit_clock,
	output logic      frame_sync,
	output logic      play_data,
	input  wire logic rec_data
);
	logic [15:0] rx_word;

	initial begin
		bit_clock = 1'h0;
		frame_sync = 1'h1;
		play_data = 1'h0;
		rx_word = 16'h0000;
	end

	// Sync low for 32 bit clocks, the word starts lead clocks in; the bit clock stands still between frames
	task automatic frame(input logic [15:0] tx, input int lead);
		for (int i = 0; i < 32; i++) begin
			repeat (8) @(posedge core_clk);
			bit_clock <= 1'h0;
			if (i == 0)
				frame_sync <= 1'h0;
			// Outside the word the line toggles so a stale bit can never look valid
			if (i >= lead && i < lead + 16)
				play_data <= tx[15 - (i - lead)];
			else
				play_data <= ~play_data;
			repeat (8) @(posedge core_clk);
			bit_clock <= 1'h1;
			if (i >= lead && i < lead + 16)
				rx_word[15 - (i - lead)] <= rec_data;
		end
		frame_sync <= 1'h1;
	endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        core_clk = 1'h0;
	logic        reset_n = 1'h0;
	logic        hsel = 1'h0;
	logic        hwrite = 1'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        mclk = 1'h0;
	logic        pclk = 1'h0;
	logic        host_bclk;
	logic        host_fsync;
	logic        host_data;
	logic        rec_out;
	logic        bclk_out;
	logic        bclk_oe_n;
	logic        fsync_out;
	logic        fsync_oe_n;
	logic [15:0] rec_sample = 16'h0;
	logic [15:0] play_sample;
	logic        rec_taken;
	logic        play_valid;
	logic        sample_tick;
	logic [2:0]  rate_code;
	int          miscompares = 0;
	int          checked = 0;
	int          valid_seen = 0;
	int          taken_seen = 0;
	int          lead = 0;

	always #25 core_clk = ~core_clk;
	// Sources stay below a quarter of core_clk so every edge survives the synchroniser
	always begin
		repeat (4) @(posedge core_clk);
		mclk <= ~mclk;
	end
	always begin
		repeat (6) @(posedge core_clk);
		pclk <= ~pclk;
	end
	always @(negedge core_clk) begin
		if (play_valid === 1'h1)
			valid_seen++;
		if (rec_taken === 1'h1)
			taken_seen++;
	end

	audio_port_top uut (
		.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.master_clock_in(mclk), .pll_clock_in(pclk), .bit_clock_in(host_bclk), .bit_clock_out(bclk_out),
		.bit_clock_oe_n(bclk_oe_n), .frame_sync_in(host_fsync), .frame_sync_out(fsync_out),
		.frame_sync_oe_n(fsync_oe_n), .playback_data_in(host_data), .record_data_out(rec_out),
		.rec_sample(rec_sample), .rec_taken(rec_taken), .play_sample(play_sample), .play_valid(play_valid),
		.sample_tick(sample_tick), .filter_rate_code(rate_code)
	);

	host_port_model u_host (
		.core_clk(core_clk), .bit_clock(host_bclk), .frame_sync(host_fsync), .play_data(host_data),
		.rec_data(rec_out)
	);

	task automatic report_and_stop();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic timed_out();
		miscompares++;
		report_and_stop();
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		checked++;
		if (seen !== expected) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, expected);
		end
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge core_clk);
		while (hreadyout !== 1'h1) begin
			n++;
			if (n > 64)
				timed_out();
			@(posedge core_clk);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wdata, output logic [31:0] rdata);
		@(posedge core_clk);
		hsel <= 1'h1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_ready();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wdata;
		wait_ready();
		rdata = hrdata;
	endtask

	// Rise to rise spacing of a pin; the early intervals are skipped since they may straddle a setting change
	task automatic measure(input int sel, output int len);
		int   n;
		int   last;
		int   rises;
		logic prev;
		logic now_v;
		n = 0;
		last = 0;
		rises = 0;
		prev = 1'h1;
		while (rises < 4) begin
			@(negedge core_clk);
			n++;
			if (n > 30000)
				timed_out();
			now_v = (sel == 0) ? bclk_out : (sel == 1) ? fsync_out : sample_tick;
			if (now_v === 1'h1 && prev !== 1'h1) begin
				rises++;
				len = n - last;
				last = n;
			end
			prev = now_v;
		end
	endtask

	task automatic test_reset();
		logic [31:0] r;
		check({31'h0, bclk_oe_n}, 32'h1);
		check({31'h0, fsync_oe_n}, 32'h1);
		check({31'h0, hresp}, 32'h0);
		bus(1'h0, 8'h06, 32'h0, r);
		check(r, 32'h140);
		bus(1'h0, 8'h05, 32'h0, r);
		check(r, 32'h0);
		bus(1'h0, 8'h07, 32'h0, r);
		check(r, 32'h0);
		bus(1'h1, 8'h30, 32'h1FF, r);
		bus(1'h0, 8'h30, 32'h0, r);
		check(r, 32'h0);
	endtask

	task automatic test_rates();
		logic [31:0] r;
		for (int c = 0; c < 6; c++) begin
			bus(1'h1, 8'h07, 32'(c * 2), r);
			bus(1'h0, 8'h07, 32'h0, r);
			check(r, 32'(c * 2));
			check({29'h0, rate_code}, 32'(c));
		end
	endtask

	task automatic test_clocks();
		logic [31:0] r;
		int          len;
		logic [8:0]  cfg [7] = '{9'h001, 9'h005, 9'h009, 9'h015, 9'h021, 9'h041, 9'h101};
		int          exp_len [7] = '{8, 16, 32, 256, 12, 16, 12};
		for (int i = 0; i < 7; i++) begin
			bus(1'h1, 8'h06, {23'h0, cfg[i]}, r);
			@(negedge core_clk);
			check({31'h0, bclk_oe_n}, 32'h0);
			measure(0, len);
			check(32'(len), 32'(exp_len[i]));
		end
		bus(1'h1, 8'h06, 32'h001, r);
		bus(1'h1, 8'h04, 32'h058, r);
		measure(1, len);
		check(32'(len), 32'h200);
		measure(2, len);
		check(32'(len), 32'h800);
		bus(1'h1, 8'h05, 32'h020, r);
		measure(1, len);
		check(32'(len), 32'h40);
	endtask

	task automatic serial_case(input logic [8:0] comp, input logic [15:0] rec, input logic [15:0] tx,
		input logic [15:0] mask, input logic [15:0] rx_exp, input logic [15:0] play_exp);
		logic [31:0] r;
		int          v0;
		int          t0;
		bus(1'h1, 8'h05, {23'h0, comp}, r);
		rec_sample <= rec;
		v0 = valid_seen;
		t0 = taken_seen;
		u_host.frame(tx, lead);
		repeat (8) @(posedge core_clk);
		check({16'h0, u_host.rx_word & mask}, {16'h0, rx_exp});
		check({16'h0, play_sample}, {16'h0, play_exp});
		check(32'(valid_seen - v0), 32'h1);
		check(32'(taken_seen - t0), 32'h1);
	endtask

	task automatic test_serial();
		logic [31:0] r;
		bus(1'h1, 8'h06, 32'h140, r);
		bus(1'h1, 8'h04, 32'h048, r);
		@(negedge core_clk);
		check({31'h0, bclk_oe_n}, 32'h1);
		lead = 0;
		serial_case(9'h000, 16'h1234, 16'hA5C3, 16'hFFFF, 16'h1234, 16'hA5C3);
		serial_case(9'h010, 16'h0000, 16'hFF00, 16'hFFFF, 16'h0000, 16'h0000);
		serial_case(9'h010, 16'h0000, 16'h8000, 16'hFFFF, 16'h0000, 16'h7D7C);
		serial_case(9'h004, 16'h0000, 16'h0000, 16'hFF00, 16'hFF00, 16'h0000);
		serial_case(9'h004, 16'h7FFF, 16'h0000, 16'hFF00, 16'h8000, 16'h0000);
		serial_case(9'h004, 16'h8000, 16'h0000, 16'hFF00, 16'h0000, 16'h0000);
		serial_case(9'h006, 16'h0000, 16'h0000, 16'hFF00, 16'hD500, 16'h0000);
		serial_case(9'h006, 16'h7FFF, 16'h0000, 16'hFF00, 16'hAA00, 16'h0000);
		serial_case(9'h006, 16'h8000, 16'h0000, 16'hFF00, 16'h2A00, 16'h0000);
		serial_case(9'h001, 16'h5A3C, 16'h0000, 16'hFFFF, 16'h5A3C, 16'h5A3C);
	endtask

	// I2S puts the MSB one clock in, right justified sixteen clocks in
	task automatic test_formats();
		logic [31:0] r;
		bus(1'h1, 8'h04, 32'h050, r);
		lead = 1;
		serial_case(9'h000, 16'h3C5A, 16'h96E1, 16'hFFFF, 16'h3C5A, 16'h96E1);
		bus(1'h1, 8'h04, 32'h040, r);
		lead = 16;
		serial_case(9'h018, 16'h0000, 16'hD500, 16'hFFFF, 16'h0000, 16'h0008);
		serial_case(9'h000, 16'hC3A5, 16'h5A69, 16'hFFFF, 16'hC3A5, 16'h5A69);
	endtask

	initial begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'h1;
		@(posedge core_clk);
		test_reset();
		test_rates();
		test_clocks();
		test_serial();
		test_formats();
		report_and_stop();
	end
endmodule
